// *** testbench/interrupt_stack_reset_unit_bench.sv ***
// Self-checking bench of the interrupt, stack and reset unit
`timescale 1ns/1ps
`include "isru_consts.svh"
module interrupt_stack_reset_unit_bench;
   import isru_pkg::*;
   localparam int RC = 8; // Short start-up count keeps the run brief
   logic clk = 0, rst_n = 0, low_voltage_reset = 0, wdg = 0, slow = 0, opt = 0, push = 0, pop = 0;
   logic srst = 0, spwr = 0, smask = 0, trap = 0, ret = 0, wfi = 0, halt = 0, pslow = 0;
   logic flash = 0, esus = 0, regwr = 0, xrst = 0, pin_o, oe, cen, uen, iend, mask, run;
   logic [7:0] spd = 8'h00, ext = 8'hCC, radr = 8'h08, rwd = 8'h00, rrd, bad;
   logic [2:0] pset = 3'h0, pen = 3'h0, pwr0 = 3'h0, psr = 3'h0, pas = 3'h0, ppend;
   logic [15:0] sp;
   wire pin_n;
   isru_stk_s stk;
   isru_vec_s vec;
   int failures = 0, total_checks = 0, sp_m, sd = 45256;
   always #50 clk = ~clk;
   // Reset pin is open drain with a pull-up; xrst is an outside driver
   assign pin_n = oe ? pin_o : ~xrst;
   isru_top #(.RST_CYCLES(RC)) i_isru_top (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .RESET_PIN_N_I(pin_n), .RESET_PIN_O(pin_o),
      .RESET_PIN_OE_O(oe), .LOW_VOLTAGE_RESET_I(low_voltage_reset), .WDG_RESET_I(wdg), .OSC_ACTIVE_I(1'b1),
      .SLOW_CLOCK_SELECT_I(slow), .OSC_FREQ_OPTION_I(opt), .CORE_CLK_EN_O(cen),
      .USB_CLK_EN_O(uen), .INSTR_END_I(iend), .PUSH_I(push), .POP_I(pop),
      .STACK_RESET_INSTR_I(srst), .SP_WR_I(spwr), .SP_WDATA_I(spd), .SET_MASK_I(smask),
      .CLR_MASK_I(1'b0), .TRAP_I(trap), .RETURN_FROM_HANDLER_I(ret), .WAIT_I(wfi),
      .HALT_I(halt), .FLASH_REQ_I(flash), .USB_ESUSP_I(esus), .EXT_INT_LINE_I(ext),
      .PERIPH_SET_I(pset), .PERIPH_EN_I(pen), .PERIPH_WR0_I(pwr0), .PERIPH_SR_ACC_I(psr),
      .PERIPH_ASSOC_ACC_I(pas), .PERIPH_PEND_O(ppend), .REG_WR_I(regwr), .REG_ADDR_I(radr),
      .REG_WDATA_I(rwd), .REG_RDATA_O(rrd), .STACK_PTR_O(sp), .MASK_O(mask),
      .CORE_RUN_O(run), .STK_O(stk), .VEC_O(vec));
   isru_cpu_model i_isru_cpu_model (.clk_i(clk), .core_en_i(cen), .slow_i(pslow),
      .stk_i(stk), .instr_end_o(iend), .bad_o(bad));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string nm, input logic [15:0] seen, input int exp);
      total_checks++;
      if (seen !== 16'(exp))
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, 16'(exp), seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Inputs move 1 ns after the rising edge
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Model pointer: only the low seven bits move, wrapping silently
   function automatic int nxt(input int s, input int d);
      return (int'(`ISRU_SP_HI_FIXED) << 7) | ((s + d) & 'h7F);
   endfunction
   // Bounded wait for one event kind, returns cycles spent
   task automatic await(input int k, output int n);
      logic hit;
      hit = 0;
      n = 0;
      while (!hit && n < 20000)
      begin
         step();
         n++;
         case (k)
            0: hit = stk.we === 1'b1;
            1: hit = stk.re === 1'b1;
            2: hit = vec.rd === 1'b1;
            3: hit = cen === 1'b1;
            4: hit = uen === 1'b1;
            5: hit = oe === 1'b1;
            default: hit = run === 1'b0;
         endcase
      end
      check("event seen", 16'(hit), 1);
   endtask
   // Context frame of five bytes, then the two vector bytes
   task automatic enter(input int base);
      int n;
      for (int i = 0; i < 5; i++)
      begin
         await(0, n);
         check("push addr", stk.addr, sp_m);
         check("push byte", 16'(stk.sel), i);
         sp_m = nxt(sp_m, -1);
      end
      await(2, n);
      check("vector high", 16'(vec.hi), 1);
      check("vector addr", vec.addr, base);
      await(2, n);
      check("vector low", vec.addr, base + 1);
      step(4);
      check("mask set", 16'(mask), 1);
   endtask
   task automatic leave();
      int n;
      ret = 1;
      for (int i = 4; i >= 0; i--)
      begin
         await(1, n);
         ret = 0;
         sp_m = nxt(sp_m, 1);
         check("pop addr", stk.addr, sp_m);
         check("pop byte", 16'(stk.sel), i);
      end
      step(5);
      check("mask clear", 16'(mask), 0);
      check("pointer", sp, sp_m);
   endtask
   task automatic boot();
      int n;
      await(2, n);
      check("start delay", 16'(n >= 3 * RC), 1);
      check("reset vector", vec.addr, `ISRU_VEC_TOP);
      await(2, n);
      check("reset vector low", vec.addr, `ISRU_VEC_TOP + 1);
      sp_m = 'h1FF;
      check("pointer reset", sp, sp_m);
      step(6);
      check("running", 16'(run), 1);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      int n, k;
      step(10);
      check("reset pointer", sp, 'h1FF);
      check("reset mask", 16'(mask), 1);
      check("reset pending", 16'(ppend), 0);
      rst_n = 1;
      boot();
      check("enable reg reset", 16'(rrd), `ISRU_EXT_EN_RST);
      // Core enable spacing in normal and slow mode
      for (int s = 0; s < 2; s++)
      begin
         slow = s[0];
         await(3, n);
         await(3, n);
         await(3, n);
         check("core period", 16'(n), 3 * (s + 1));
      end
      slow = 0;
      for (int o = 0; o < 2; o++)
      begin
         opt = o[0];
         await(4, n);
         await(4, n);
         await(4, n);
         check("usb period", 16'(n), 2 + 2 * o);
      end
      // Random pushes and pops, with a forced downward wrap first
      for (int i = 0; i < 160; i++)
      begin
         k = $random(sd);
         push = i < 130 || k[0];
         pop = !push;
         step();
         sp_m = nxt(sp_m, push ? -1 : 1);
         check("pointer move", sp, sp_m);
      end
      push = 0;
      pop = 0;
      spwr = 1;
      spd = 8'(k >> 8);
      step();
      spwr = 0;
      check("pointer load", sp, nxt(int'(spd), 0));
      srst = 1;
      step();
      srst = 0;
      sp_m = 'h1FF;
      check("stack reset", sp, sp_m);
      // Trap while masked, then two requests at once
      trap = 1;
      step();
      trap = 0;
      enter(`ISRU_VEC_TOP - 2);
      leave();
      flash = 1;
      esus = 1;
      step();
      flash = 0;
      esus = 0;
      enter(`ISRU_VEC_TOP - 4);
      leave();
      enter(`ISRU_VEC_TOP - 6);
      leave();
      // Peripheral flags: disabled stays pending, clear in handler
      pslow = 1;
      for (int p = 0; p < 3; p++)
      begin
         pen = 0;
         pset = 3'(1 << p);
         step();
         pset = 0;
         step(20);
         check("held pending", 16'(ppend), 1 << p);
         check("no entry", sp, sp_m);
         pen = 3'(1 << p);
         enter(`ISRU_VEC_TOP - 2 * (p == 0 ? 5 : p + 6));
         check("kept pending", 16'(ppend), 1 << p);
         if (p == 0)
            pwr0 = 3'h1;
         else
            psr = 3'(1 << p);
         step();
         pwr0 = 0;
         psr = 0;
         pas = 3'(p == 0 ? 0 : 1 << p);
         step();
         pas = 0;
         step(2);
         check("cleared", 16'(ppend), 0);
         leave();
      end
      pslow = 0;
      // External lines: rising on line 1, falling on line 3
      for (int e = 0; e < 2; e++)
      begin
         rwd = e ? 8'h04 : 8'h01;
         regwr = 1;
         step();
         regwr = 0;
         step(2);
         check("enable reg", 16'(rrd), int'(rwd));
         ext = e ? 8'hC9 : 8'hCD;
         enter(`ISRU_VEC_TOP - 8);
         leave();
      end
      // Wait wakes on flash request; halt ignores timer, wakes on end-suspend
      wfi = 1;
      await(6, n);
      wfi = 0;
      flash = 1;
      step();
      flash = 0;
      enter(`ISRU_VEC_TOP - 4);
      leave();
      smask = 1;
      step(4);
      smask = 0;
      halt = 1;
      await(6, n);
      halt = 0;
      step(4);
      check("halt unmasks", 16'(mask), 0);
      pen = 3'h1;
      pset = 3'h1;
      step();
      pset = 0;
      step(30);
      check("still halted", 16'(run), 0);
      esus = 1;
      step();
      esus = 0;
      enter(`ISRU_VEC_TOP - 6);
      pwr0 = 3'h1;
      step();
      pwr0 = 0;
      leave();
      // Watchdog then low-voltage reset drive the pin and restart
      for (int r = 0; r < 2; r++)
      begin
         // Source held until the pin drive shows, as it lasts one clock
         {low_voltage_reset, wdg} = 2'(1 << r);
         await(5, n);
         {low_voltage_reset, wdg} = 2'h0;
         check("pin driven low", 16'(n <= 4 && pin_n === 1'b0), 1);
         boot();
      end
      // outside party holds the pin low five clocks
      xrst = 1;
      step(5);
      xrst = 0;
      check("outside reset", 16'(!run && !oe), 1);
      boot();
      check("stack order", 16'(bad), 0);
      wrap_up();
   end
   // Watchdog on a hung run
   initial
   begin
      #2000000;
      failures++;
      wrap_up();
   end
endmodule // interrupt_stack_reset_unit_bench

// *** testbench/isru_cpu_model.sv ***
// Stand-in for the sequencer side: instruction ends and stack memory
`timescale 1ns/1ps
module isru_cpu_model
   import isru_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       core_en_i,
   input  wire logic       slow_i,
   input  wire isru_stk_s  stk_i,
   output logic            instr_end_o = 1'b1,
   output logic [7:0]      bad_o = 8'h00
);
   logic [2:0] mem [0:511]; // Context tag of each stack byte
   // Slow mode ends an instruction only every other core cycle
   always @(posedge clk_i)
      if (core_en_i)
         instr_end_o <= slow_i ? ~instr_end_o : 1'b1;
   // bytes must come back tagged as they were stored
   always @(posedge clk_i)
      if (stk_i.we)
         mem[stk_i.addr[8:0]] <= stk_i.sel;
      else if (stk_i.re && mem[stk_i.addr[8:0]] !== stk_i.sel)
         bad_o <= bad_o + 8'h01;
endmodule // isru_cpu_model

// *** verilog/isru_consts.svh ***
// Constants of the interrupt, stack and reset unit
`ifndef ISRU_CONSTS_SVH
`define ISRU_CONSTS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define ISRU_EXT_EN_OFS   8'h08
`define ISRU_EXT_EN_RST   8'h00
// ----------------------------------------
// Stack pointer
// ----------------------------------------
`define ISRU_SP_HI_FIXED  9'h003
`define ISRU_SP_LO_RST    8'hFF
`define ISRU_SP_LO_BITS   7
`define ISRU_FRAME_LAST   3'h4
// ----------------------------------------
// Vectors and sources
// ----------------------------------------
`define ISRU_VEC_TOP      16'hFFFE
`define ISRU_SRC_TRAP     4'h1
`define ISRU_SRC_USBES    4'h3
`define ISRU_SRC_EXT      4'h4
`define ISRU_NUM_SRC      9
// Rising-edge lines 1,2,5,6 on bits 0,1,4,5
`define ISRU_EXT_RISE     8'h33
// ----------------------------------------
// Clocking and reset timing
// ----------------------------------------
`define ISRU_CORE_DIV     2'h2
`define ISRU_USB_DIV24    2'h3
`define ISRU_USB_DIV12    2'h1
`define ISRU_RST_CYCLES   4096
`endif

// *** verilog/isru_pkg.sv ***
// Types of the interrupt, stack and reset unit
package isru_pkg;
   // Sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_HOLD  = 8'h02,
      ST_VEC_H = 8'h04,
      ST_VEC_L = 8'h08,
      ST_PUSH  = 8'h10,
      ST_POP   = 8'h20,
      ST_WAIT  = 8'h40,
      ST_HALT  = 8'h80
   } isru_state_e;
   // Context byte on the stack port
   typedef enum logic [2:0] {
      CTX_PCL = 3'h0,
      CTX_PCH = 3'h1,
      CTX_X   = 3'h2,
      CTX_A   = 3'h3,
      CTX_CC  = 3'h4
   } isru_ctx_e;
   // Stack access to the sequencer
   typedef struct packed {
      logic        we;
      logic        re;
      logic [15:0] addr;
      isru_ctx_e   sel;
   } isru_stk_s;
   // Vector byte fetch
   typedef struct packed {
      logic        rd;
      logic        hi;
      logic [15:0] addr;
   } isru_vec_s;
   typedef logic [3:0] isru_idx_t;
endpackage

// *** verilog/isru_top.sv ***
// Interrupt, stack pointer, reset and clock enable unit of the core
// How it works
// - Pointer names next free byte, post-decrement push
// - Upper nine pointer bits fixed in hardware
// - Reset or stack-reset sets low byte ones
// - Pointer wraps silently both ways
// - Low program counter byte pushed first
// - Call two bytes, interrupt five bytes
// - Reset fetches vector from topmost pair
// - Hold core 4096 core cycles after oscillator
// - Three reset sources; internal ones drive pin
// - Core rate oscillator/3, slow halves again
// - Option picks USB divider for 6 MHz
// - Entry pushes context, masks, loads vector
// - Return pops context, mask left clear
// - Masked requests stay latched until unmasked
// - Fixed priority among pending requests
// - Flash, trap, end-suspend vector pairs
// - Trap enters whatever the mask
// - Wait ends on any; halt on few
// - Edge lines with enable and clear mask
// - Peripheral flag needs enable and clear mask
// - Latch cleared by zero write or sequence
// - Entering halt clears the mask
`timescale 1ns/1ps
`include "isru_consts.svh"
module isru_top
   import isru_pkg::*;
#(
   parameter int RST_CYCLES = `ISRU_RST_CYCLES
)(
   input  wire logic       SYS_CLK_I,
   input  wire logic       RST_N_I,
   input  wire logic       RESET_PIN_N_I,
   output logic            RESET_PIN_O,
   output logic            RESET_PIN_OE_O,
   input  wire logic       LOW_VOLTAGE_RESET_I,
   input  wire logic       WDG_RESET_I,
   input  wire logic       OSC_ACTIVE_I,
   input  wire logic       SLOW_CLOCK_SELECT_I,
   input  wire logic       OSC_FREQ_OPTION_I,
   output logic            CORE_CLK_EN_O,
   output logic            USB_CLK_EN_O,
   input  wire logic       INSTR_END_I,
   input  wire logic       PUSH_I,
   input  wire logic       POP_I,
   input  wire logic       STACK_RESET_INSTR_I,
   input  wire logic       SP_WR_I,
   input  wire logic [7:0] SP_WDATA_I,
   input  wire logic       SET_MASK_I,
   input  wire logic       CLR_MASK_I,
   input  wire logic       TRAP_I,
   input  wire logic       RETURN_FROM_HANDLER_I,
   input  wire logic       WAIT_I,
   input  wire logic       HALT_I,
   input  wire logic       FLASH_REQ_I,
   input  wire logic       USB_ESUSP_I,
   input  wire logic [7:0] EXT_INT_LINE_I,
   input  wire logic [2:0] PERIPH_SET_I,
   input  wire logic [2:0] PERIPH_EN_I,
   input  wire logic [2:0] PERIPH_WR0_I,
   input  wire logic [2:0] PERIPH_SR_ACC_I,
   input  wire logic [2:0] PERIPH_ASSOC_ACC_I,
   output logic [2:0]      PERIPH_PEND_O,
   input  wire logic       REG_WR_I,
   input  wire logic [7:0] REG_ADDR_I,
   input  wire logic [7:0] REG_WDATA_I,
   output logic [7:0]      REG_RDATA_O,
   output logic [15:0]     STACK_PTR_O,
   output logic            MASK_O,
   output logic            CORE_RUN_O,
   output isru_stk_s       STK_O,
   output isru_vec_s       VEC_O
);
   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Vector pair base, source n at top minus 2n
   function automatic logic [15:0] vec_base(input isru_idx_t n);
      vec_base = `ISRU_VEC_TOP - {11'h000, n, 1'b0};
   endfunction
   // Lowest index wins
   function automatic isru_idx_t pick(input logic [8:0] r);
      pick = 4'h0;
      for (int i = `ISRU_NUM_SRC - 1; i > 0; i--)
         if (r[i])
            pick = 4'(i);
   endfunction
   // Low seven bits move, upper bits forced
   function automatic logic [15:0] sp_make(input logic [6:0] lo);
      sp_make = {`ISRU_SP_HI_FIXED, lo};
   endfunction
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   isru_state_e state;            // Sequencer state
   logic [15:0] stack_pointer;    // Stack pointer
   logic [2:0]  cnt;              // Context byte count
   isru_idx_t   cur_idx;          // Source being entered
   logic        mask;             // Global mask bit
   logic        wake_int;         // Halt left by interrupt
   logic [12:0] hold_cnt;         // Start-up delay count
   logic [1:0]  div3;             // Divide by three
   logic        half;             // Slow mode halver
   logic [1:0]  usb_div;          // USB divider
   logic        ce;               // Core clock enable
   logic [1:0]  pin_sy;           // Reset pin sync
   logic [1:0]  lvd_sy;           // Low voltage sync
   logic [7:0]  ext_s1;           // Line sync stage one
   logic [7:0]  ext_s2;           // Line sync stage two
   logic [7:0]  ext_d;            // Line previous value
   logic [7:0]  ext_en;           // Line enable register
   logic        ext_pend;         // External latch
   logic        trap_pend;        // Trap latch
   logic        flash_pend;       // Flash latch
   logic        usbes_pend;       // End-suspend latch
   logic [2:0]  per_pend;         // Peripheral latches
   logic [2:0]  per_arm;          // Status seen while set
   logic [8:0]  req;              // Requests by index
   logic [8:0]  masked;           // Requests after mask
   logic        int_rst;          // Internal reset request
   logic        any_req;          // Something pending
   logic        halt_wake;        // Halt exit source
   isru_idx_t   win;              // Arbitration winner
   logic [7:0]  ext_edge;         // Active edges seen
   logic        take;             // Start an entry
   // ----------------------------------------
   // Clock enables
   // ----------------------------------------
   // Core enable every third clock, every sixth in slow mode
   // divide three, slow halves
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_N_I)
      begin
         div3 <= 2'h0;
         half <= 1'b0;
      end
      else if (div3 == `ISRU_CORE_DIV)
      begin
         div3 <= 2'h0;
         half <= ~half;
      end
      else
         div3 <= div3 + 2'h1;
   end
   assign ce = (div3 == `ISRU_CORE_DIV) & (~SLOW_CLOCK_SELECT_I | half);
   assign CORE_CLK_EN_O = ce;
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_N_I)
         usb_div <= 2'h0;
      else if (usb_div >= (OSC_FREQ_OPTION_I ? `ISRU_USB_DIV24 : `ISRU_USB_DIV12))
         usb_div <= 2'h0;
      else
         usb_div <= usb_div + 2'h1;
   end
   assign USB_CLK_EN_O = (usb_div == (OSC_FREQ_OPTION_I ? `ISRU_USB_DIV24 : `ISRU_USB_DIV12));
   // ----------------------------------------
   // Reset sources
   // ----------------------------------------
   // Pins pass two flops before any use
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_N_I)
      begin
         pin_sy <= 2'h3;
         lvd_sy <= 2'h0;
         ext_s1 <= 8'h00;
         ext_s2 <= 8'h00;
         ext_d  <= 8'h00;
      end
      else
      begin
         pin_sy <= {pin_sy[0], RESET_PIN_N_I};
         lvd_sy <= {lvd_sy[0], LOW_VOLTAGE_RESET_I};
         ext_s1 <= EXT_INT_LINE_I;
         ext_s2 <= ext_s1;
         ext_d  <= ext_s2;
      end
   end
   // short pulse still sampled every clock
   assign int_rst = lvd_sy[1] | WDG_RESET_I | ~pin_sy[1];
   // internal sources pull the pin low
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_N_I)
         RESET_PIN_OE_O <= 1'b0;
      else
         RESET_PIN_OE_O <= lvd_sy[1] | WDG_RESET_I;
   end
   assign RESET_PIN_O = 1'b0;
   // ----------------------------------------
   // Register port and edge lines
   // ----------------------------------------
   // Enable register, read back on every clock
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_N_I)
      begin
         ext_en      <= `ISRU_EXT_EN_RST;
         REG_RDATA_O <= 8'h00;
      end
      else
      begin
         if (REG_WR_I && REG_ADDR_I == `ISRU_EXT_EN_OFS)
            ext_en <= REG_WDATA_I;
         REG_RDATA_O <= (REG_ADDR_I == `ISRU_EXT_EN_OFS) ? ext_en : 8'h00;
      end
   end
   // rising or falling edge per line
   assign ext_edge = ((ext_s2 & ~ext_d & `ISRU_EXT_RISE) |
                      (~ext_s2 & ext_d & ~`ISRU_EXT_RISE)) & ext_en;
   // ----------------------------------------
   // Request latches
   // ----------------------------------------
   // Set beats clear; entry clears its own latch
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_N_I || int_rst)
      begin
         ext_pend   <= 1'b0;
         trap_pend  <= 1'b0;
         flash_pend <= 1'b0;
         usbes_pend <= 1'b0;
      end
      else
      begin
         ext_pend   <= (|ext_edge) | (ext_pend & ~(take && win == `ISRU_SRC_EXT));
         trap_pend  <= TRAP_I | (trap_pend & ~(take && win == `ISRU_SRC_TRAP));
         flash_pend <= FLASH_REQ_I | (flash_pend & ~(take && win == 4'h2));
         usbes_pend <= USB_ESUSP_I | (usbes_pend & ~(take && win == `ISRU_SRC_USBES));
      end
   end
   // zero write or status then associated access
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_N_I || int_rst)
      begin
         per_pend <= 3'h0;
         per_arm  <= 3'h0;
      end
      else
      begin
         per_pend <= PERIPH_SET_I |
                     (per_pend & ~PERIPH_WR0_I & ~(per_arm & PERIPH_ASSOC_ACC_I));
         per_arm  <= ~PERIPH_SET_I & (per_arm | (PERIPH_SR_ACC_I & per_pend)) &
                     ~PERIPH_WR0_I & ~PERIPH_ASSOC_ACC_I;
      end
   end
   assign PERIPH_PEND_O = per_pend;
   // ----------------------------------------
   // Arbitration
   // ----------------------------------------
   // peripheral needs its enable
   assign req = {per_pend[2] & PERIPH_EN_I[2], per_pend[1] & PERIPH_EN_I[1], 1'b0,
                 per_pend[0] & PERIPH_EN_I[0], ext_pend, usbes_pend, flash_pend,
                 trap_pend, 1'b0};
   assign masked  = mask ? {7'h00, req[1], 1'b0} : req;
   assign win     = pick(masked);
   assign any_req = |masked;
   assign halt_wake = ext_pend | usbes_pend;
   assign take    = ce && any_req && ((state == ST_IDLE && INSTR_END_I) ||
                    state == ST_WAIT || (state == ST_HOLD && wake_int &&
                    hold_cnt == 13'(RST_CYCLES - 1) && OSC_ACTIVE_I));
   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Hold, vector fetch, push, pop and sleep
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_N_I || int_rst)
      begin
         state    <= ST_HOLD;
         cnt      <= 3'h0;
         cur_idx  <= 4'h0;
         hold_cnt <= 13'h0000;
         wake_int <= 1'b0;
      end
      else if (take)
      begin
         state    <= ST_PUSH;
         cnt      <= 3'h0;
         cur_idx  <= win;
         // Restart the count so a later halt waits out the full delay
         hold_cnt <= 13'h0000;
         wake_int <= 1'b0;
      end
      else if (ce)
      begin
         case (state)
            ST_IDLE:
            begin
               if (RETURN_FROM_HANDLER_I)
                  state <= ST_POP;
               else if (HALT_I)
                  state <= ST_HALT;
               else if (WAIT_I)
                  state <= ST_WAIT;
               cnt <= 3'h0;
            end
            // count core cycles once oscillator runs
            ST_HOLD:
            begin
               if (OSC_ACTIVE_I && hold_cnt == 13'(RST_CYCLES - 1))
               begin
                  hold_cnt <= 13'h0000;
                  state    <= wake_int ? ST_IDLE : ST_VEC_H;
                  wake_int <= 1'b0;
               end
               else if (OSC_ACTIVE_I)
                  hold_cnt <= hold_cnt + 13'h0001;
            end
            ST_PUSH:
            begin
               if (cnt == `ISRU_FRAME_LAST)
                  state <= ST_VEC_H;
               cnt <= cnt + 3'h1;
            end
            ST_POP:
            begin
               if (cnt == `ISRU_FRAME_LAST)
                  state <= ST_IDLE;
               cnt <= cnt + 3'h1;
            end
            // high byte first at even address
            ST_VEC_H: state <= ST_VEC_L;
            ST_VEC_L: state <= ST_IDLE;
            ST_WAIT:  state <= ST_WAIT;
            ST_HALT:
            begin
               if (halt_wake)
               begin
                  state    <= ST_HOLD;
                  wake_int <= 1'b1;
               end
            end
            default:  state <= ST_HOLD;
         endcase
      end
   end
   // ----------------------------------------
   // Global mask
   // ----------------------------------------
   // Set by reset and entry, cleared by return and sleep
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_N_I || int_rst)
         mask <= 1'b1;
      else if (ce && state == ST_VEC_H)
         mask <= 1'b1;
      else if (ce && state == ST_POP && cnt == `ISRU_FRAME_LAST)
         mask <= 1'b0;
      // halt and wait clear the mask
      else if (state == ST_HALT || state == ST_WAIT)
         mask <= 1'b0;
      else if (SET_MASK_I)
         mask <= 1'b1;
      else if (CLR_MASK_I)
         mask <= 1'b0;
   end
   assign MASK_O = mask;
   // ----------------------------------------
   // Stack pointer
   // ----------------------------------------
   // Only low seven bits count, so wrap is free
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!RST_N_I || int_rst || STACK_RESET_INSTR_I)
         stack_pointer <= sp_make(7'(`ISRU_SP_LO_RST));
      else if ((ce && state == ST_PUSH) || (state == ST_IDLE && PUSH_I))
         stack_pointer <= sp_make(stack_pointer[6:0] - 7'h01);
      else if ((ce && state == ST_POP) || (state == ST_IDLE && POP_I))
         stack_pointer <= sp_make(stack_pointer[6:0] + 7'h01);
      // loaded low byte keeps forced bits
      else if (SP_WR_I)
         stack_pointer <= sp_make(SP_WDATA_I[6:0]);
   end
   assign STACK_PTR_O = stack_pointer;
   // ----------------------------------------
   // Sequencer outputs
   // ----------------------------------------
   // PROGRAM_COUNTER_LOW first, lower addresses follow
   assign STK_O.we   = ce && state == ST_PUSH;
   assign STK_O.re   = ce && state == ST_POP;
   assign STK_O.addr = (state == ST_POP) ? sp_make(stack_pointer[6:0] + 7'h01)
                                         : stack_pointer;
   assign STK_O.sel  = (state == ST_POP) ? isru_ctx_e'(`ISRU_FRAME_LAST - cnt)
                                         : isru_ctx_e'(cnt);
   assign VEC_O.rd   = ce && (state == ST_VEC_H || state == ST_VEC_L);
   assign VEC_O.hi   = state == ST_VEC_H;
   assign VEC_O.addr = vec_base(cur_idx) | {15'h0000, state == ST_VEC_L};
   assign CORE_RUN_O = ~(state == ST_HOLD || state == ST_HALT || state == ST_WAIT);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_frame_end;
      ce && state == ST_PUSH && cnt == `ISRU_FRAME_LAST;
   endsequence
   sequence s_vec_pair;
      state == ST_VEC_H ##[1:6] (state == ST_VEC_L && VEC_O.addr[0]);
   endsequence
   AST_SP_FIXED: assert property (stack_pointer[15:7] == `ISRU_SP_HI_FIXED)
      else $error("stack pointer upper bits moved");
   AST_SP_PUSH: assert property (state == ST_IDLE && PUSH_I && !STACK_RESET_INSTR_I &&
      !int_rst |=> stack_pointer[6:0] == $past(stack_pointer[6:0]) - 7'h01)
      else $error("push did not decrement");
   AST_SP_RSP: assert property (STACK_RESET_INSTR_I |=> stack_pointer[7:0] == 8'hFF)
      else $error("stack reset missed");
   AST_PCL_FIRST: assert property ($rose(state == ST_PUSH) |-> STK_O.sel == CTX_PCL)
      else $error("frame not started with low byte");
   AST_FRAME: assert property (s_frame_end and !int_rst |=> state == ST_VEC_H ##0
      s_vec_pair)
      else $error("frame not followed by vector fetch");
   AST_MASK_ENTRY: assert property (ce && state == ST_VEC_H && !int_rst |=> mask)
      else $error("mask not set on entry");
   AST_RET_MASK: assert property (ce && state == ST_POP && cnt == `ISRU_FRAME_LAST &&
      !int_rst |=> !mask && state == ST_IDLE)
      else $error("return left mask set");
   AST_MASKED: assert property (take && mask |-> win == `ISRU_SRC_TRAP)
      else $error("masked source entered");
   AST_VEC_HIGH: assert property (VEC_O.rd && VEC_O.hi |-> VEC_O.addr[0] == 1'b0)
      else $error("high vector byte at odd address");
   AST_HOLD: assert property (state == ST_HOLD && hold_cnt != 13'(RST_CYCLES - 1)
      && !take |=> state == ST_HOLD || $past(int_rst) == 1'b0 && state == ST_HOLD)
      else $error("left start-up delay early");
   AST_PIN: assert property (lvd_sy[1] |=> RESET_PIN_OE_O)
      else $error("low voltage did not drive pin");
endmodule // isru_top
